// [design/rmc_pkg.sv]
// Shared constants for the redriver mode-control ends
package rmc_pkg;
  // Device register offsets on the link
  localparam logic [7:0] REG_GEN = 8'h0A;
  localparam logic [7:0] REG_SBU = 8'h0B;
  localparam logic [7:0] REG_SNOOP = 8'h13;
  localparam logic [7:0] REG_EQ_BASE = 8'h20;
  localparam logic [7:0] REG_STAT = 8'h30;
  // Fields of the general and snoop registers, and reset values
  localparam int GEN_FLO = 0;
  localparam int GEN_FHI = 1;
  localparam int GEN_ORI = 2;
  localparam int GEN_DLO = 3;
  localparam int GEN_DHI = 4;
  localparam int GEN_CABLE = 6;
  localparam int SNOOP_BIT = 7;
  localparam logic [7:0] GEN_RST = 8'h00;
  localparam logic [1:0] SBU_RST = 2'h0;
  localparam logic SNOOP_RST = 1'b0;
  localparam logic [7:0] EQ_RST = 8'h00;
  // Sideband override and route codes
  localparam logic [1:0] SBU_AUTO = 2'h0;
  localparam logic [1:0] SBU_STRAIGHT = 2'h1;
  localparam logic [1:0] SBU_CROSS = 2'h2;
  localparam logic [1:0] SBU_OPEN = 2'h3;
  // Lane counts
  localparam logic [2:0] LANES_0 = 3'h0;
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;
  // Cable mode wait without USB activity before four lanes
  localparam int CABLE_USB_WAIT_CYC = 1000;
  // Controller AXI offsets and fields
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_CMD = 4'h4;
  localparam logic [3:0] A_STAT = 4'h8;
  localparam int CMD_WR_BIT = 16;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Four-level pins (0, R, F, 1 coded 0..3) to sixteen-step gain index
  function automatic logic [3:0] rmc_eq_index(input logic [1:0] hi, input logic [1:0] lo);
    rmc_eq_index = {hi, lo};
  endfunction

  // Byte-lane merge for bus writes
  function automatic logic [31:0] rmc_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
    begin
      rmc_merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction
endpackage

// [design/rmc_link_if.sv]
// Link between controller and redriver: pins plus register port
`timescale 1ns/100ps
interface rmc_link_if;
  logic interface_select;
  logic usb_function_pin;
  logic dp_function_pin;
  logic hot_plug_input;
  logic orientation_select;
  logic direction_select_hi;
  logic [1:0] down_eq_pin_hi;
  logic [1:0] down_eq_pin_lo;
  logic [1:0] up_eq_pin_hi;
  logic [1:0] up_eq_pin_lo;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_ack;
  modport dev (
    input interface_select, usb_function_pin, dp_function_pin, hot_plug_input,
    input orientation_select, direction_select_hi,
    input down_eq_pin_hi, down_eq_pin_lo, up_eq_pin_hi, up_eq_pin_lo,
    input reg_addr, reg_wdata, reg_wr, reg_rd,
    output reg_rdata, reg_ack
  );
  modport host (
    output interface_select, usb_function_pin, dp_function_pin, hot_plug_input,
    output orientation_select, direction_select_hi,
    output down_eq_pin_hi, down_eq_pin_lo, up_eq_pin_hi, up_eq_pin_lo,
    output reg_addr, reg_wdata, reg_wr, reg_rd,
    input reg_rdata, reg_ack
  );
endinterface

// [design/rmc_pin_sync.sv]
// Three-flop pin synchroniser, output follows when stages two and three agree
`timescale 1ns/100ps
module rmc_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } rmc_sync_s;
  rmc_sync_s s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.s1 = pin_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (s_q.s2[i] == s_q.s3[i])
      begin
        s_d.o[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pin_o = s_q.o;
endmodule // rmc_pin_sync

// [design/rmc_device.sv]
// Redriver mode, sideband routing, cable mode and equalization control
// Summary of operation
// R01: All five select bits high: USB, flipped custom.
// R02: Sideband 00 auto, 01/10 straight/crossed, 11 open.
// R03: GPIO mode: DP enable follows control pins.
// R04: GPIO mode: custom enable follows control pins.
// R05: Host clears snoop inhibit before register custom mode.
// R06: GPIO cable mode: both control pins held low.
// R07: Register cable mode: host sets general bit 6.
// R08: Cable mode picks USB/DP itself, on the fly.
// R09: Controller drives hot plug input in cable mode.
// R10: Cable: hot plug high DP, low USB only.
// R11: Cable: snooping on, snooped training sets lanes.
// R12: Snooping off: two lanes on hot plug.
// R13: Snooping off: four lanes without USB activity.
// R14: Separate downstream and upstream equalization settings.
// R15: GPIO eq: two four-level pins, upper major.
// R16: Register eq: per-channel, per-direction select fields.
// R17: Interface select not low means register mode.
// R18: Register mode ignores control and eq pins.
`timescale 1ns/100ps
module rmc_device
  import rmc_pkg::*;
#(
  parameter int USB_WAIT_CYC = CABLE_USB_WAIT_CYC
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Link to the controller
  rmc_link_if.dev LINK,
  // Snoop and activity from the data path
  input wire logic SNOOP_VALID_I,
  input wire logic [2:0] SNOOP_LANES_I,
  input wire logic USB_ACTIVE_I,
  // Mode outputs
  output logic USB_EN_O,
  output logic DP_EN_O,
  output logic CUSTOM_EN_O,
  output logic FLIP_O,
  output logic SINK_SIDE_O,
  output logic CABLE_O,
  output logic [2:0] DP_LANES_O,
  output logic [1:0] SBU_ROUTE_O,
  // Equalization, channel 2 in the upper nibble
  output logic [7:0] DOWN_RX_EQ_O,
  output logic [7:0] DOWN_TX_EQ_O,
  output logic [7:0] UP_RX_EQ_O,
  output logic [7:0] UP_TX_EQ_O
);
  typedef enum logic [3:0] {
    C_USB = 4'b0001,
    C_DP2 = 4'b0010,
    C_DP4 = 4'b0100,
    C_SNP = 4'b1000
  } rmc_cable_e;

  typedef struct packed {
    logic if_sel;
    logic usb;
    logic dp;
    logic hpd;
    logic ori;
    logic dhi;
    logic [1:0] dh;
    logic [1:0] dl;
    logic [1:0] uh;
    logic [1:0] ul;
  } rmc_pins_s;

  typedef struct packed {
    logic [7:0] gen;
    logic [1:0] sbu;
    logic snoop_inh;
    logic [3:0][7:0] eq;
    logic [7:0] rdata;
    logic ack;
    rmc_cable_e cst;
    logic [15:0] tmr;
    logic [2:0] snp_lanes;
    logic usb_en;
    logic dp_en;
    logic cus_en;
    logic flip;
    logic sink;
    logic cable;
    logic [2:0] lanes;
    logic [1:0] route;
    logic [3:0][7:0] eq_out;
  } rmc_dev_s;

  rmc_dev_s s_q, s_d;
  rmc_pins_s p;

  rmc_pin_sync #(
    .W($bits(rmc_pins_s))
  ) i_rmc_pin_sync (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .pin_i({LINK.interface_select, LINK.usb_function_pin, LINK.dp_function_pin, LINK.hot_plug_input,
            LINK.orientation_select, LINK.direction_select_hi, LINK.down_eq_pin_hi, LINK.down_eq_pin_lo,
            LINK.up_eq_pin_hi, LINK.up_eq_pin_lo}),
    .pin_o(p)
  );

  logic reg_mode, f_lo, f_hi, ori, d_hi, d_lo, cable, snoop_en, alt_on;
  logic [3:0] deq, ueq;

  always_comb
  begin
    s_d = s_q;
    s_d.ack = LINK.reg_wr | LINK.reg_rd;
    // Register port
    if (LINK.reg_wr)
    begin
      case (LINK.reg_addr)
        REG_GEN: s_d.gen = LINK.reg_wdata; // R07
        REG_SBU: s_d.sbu = LINK.reg_wdata[1:0];
        REG_SNOOP: s_d.snoop_inh = LINK.reg_wdata[SNOOP_BIT];
        default:
        begin
          if (LINK.reg_addr[7:2] == REG_EQ_BASE[7:2])
          begin
            s_d.eq[LINK.reg_addr[1:0]] = LINK.reg_wdata; // R16
          end
        end
      endcase
    end
    if (LINK.reg_rd)
    begin
      case (LINK.reg_addr)
        REG_GEN: s_d.rdata = s_q.gen;
        REG_SBU: s_d.rdata = {6'h00, s_q.sbu};
        REG_SNOOP: s_d.rdata = {s_q.snoop_inh, 7'h00};
        REG_STAT: s_d.rdata = {p.if_sel, s_q.lanes, s_q.flip, s_q.cus_en, s_q.dp_en, s_q.usb_en};
        default: s_d.rdata = (LINK.reg_addr[7:2] == REG_EQ_BASE[7:2]) ? s_q.eq[LINK.reg_addr[1:0]] : 8'h00;
      endcase
    end
    // Control source selection
    reg_mode = p.if_sel; // R17
    f_lo = reg_mode ? s_q.gen[GEN_FLO] : p.usb; // R18
    f_hi = reg_mode ? s_q.gen[GEN_FHI] : p.dp; // R03 R04
    ori = reg_mode ? s_q.gen[GEN_ORI] : p.ori;
    d_hi = reg_mode ? s_q.gen[GEN_DHI] : p.dhi;
    d_lo = reg_mode ? s_q.gen[GEN_DLO] : 1'b0;
    cable = reg_mode ? s_q.gen[GEN_CABLE] : (!p.usb && !p.dp); // R06 R07
    snoop_en = reg_mode ? !s_q.snoop_inh : 1'b1; // R05 R11
    // Cable mode sequencing
    if (SNOOP_VALID_I && (SNOOP_LANES_I == LANES_1 || SNOOP_LANES_I == LANES_2 || SNOOP_LANES_I == LANES_4))
    begin
      s_d.snp_lanes = SNOOP_LANES_I; // R11
    end
    if (!cable || !p.hpd) // R09 R10
    begin
      s_d.cst = C_USB;
      s_d.tmr = '0;
      s_d.snp_lanes = LANES_2;
    end
    else
    begin
      case (s_q.cst)
        C_USB: s_d.cst = snoop_en ? C_SNP : C_DP2; // R08 R12
        C_DP2:
        begin
          if (snoop_en)
          begin
            s_d.cst = C_SNP;
          end
          else if (USB_ACTIVE_I)
          begin
            s_d.tmr = '0;
          end
          else if (s_q.tmr == 16'(USB_WAIT_CYC - 1))
          begin
            s_d.cst = C_DP4; // R13
          end
          else
          begin
            s_d.tmr = s_q.tmr + 16'h0001;
          end
        end
        C_DP4: s_d.cst = snoop_en ? C_SNP : C_DP4;
        C_SNP:
        begin
          if (!snoop_en)
          begin
            s_d.cst = C_DP2;
            s_d.tmr = '0;
          end
        end
        default: s_d.cst = C_USB;
      endcase
    end
    // Mode decode
    alt_on = f_hi;
    s_d.cable = cable;
    s_d.flip = ori;
    s_d.sink = d_lo;
    if (cable)
    begin
      s_d.dp_en = s_q.cst != C_USB; // R10
      s_d.cus_en = 1'b0;
      case (s_q.cst)
        C_DP2: s_d.lanes = LANES_2;
        C_DP4: s_d.lanes = LANES_4;
        C_SNP: s_d.lanes = s_q.snp_lanes;
        default: s_d.lanes = LANES_0;
      endcase
      s_d.usb_en = (s_q.cst != C_DP4) && !(s_q.cst == C_SNP && s_q.snp_lanes == LANES_4);
      alt_on = s_q.cst != C_USB;
    end
    else
    begin
      s_d.usb_en = f_lo;
      s_d.dp_en = f_hi && !d_hi; // R03
      s_d.cus_en = f_hi && d_hi; // R01 R04
      s_d.lanes = (f_hi && !d_hi) ? (f_lo ? LANES_2 : LANES_4) : LANES_0;
    end
    // Sideband crosspoint
    case (reg_mode ? s_q.sbu : SBU_AUTO) // R02
      SBU_STRAIGHT: s_d.route = SBU_STRAIGHT;
      SBU_CROSS: s_d.route = SBU_CROSS;
      SBU_OPEN: s_d.route = SBU_OPEN;
      default: s_d.route = !alt_on ? SBU_OPEN : (ori ? SBU_CROSS : SBU_STRAIGHT);
    endcase
    // Equalization per direction, pins or registers
    deq = rmc_eq_index(p.dh, p.dl); // R15
    ueq = rmc_eq_index(p.uh, p.ul);
    s_d.eq_out = reg_mode ? s_q.eq : {{ueq, ueq}, {ueq, ueq}, {deq, deq}, {deq, deq}}; // R14 R16 R18
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      s_q <= '0;
      s_q.gen <= GEN_RST;
      s_q.sbu <= SBU_RST;
      s_q.snoop_inh <= SNOOP_RST;
      s_q.eq <= {4{EQ_RST}};
      s_q.cst <= C_USB;
      s_q.snp_lanes <= LANES_2;
      s_q.eq_out <= {4{EQ_RST}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign LINK.reg_rdata = s_q.rdata;
  assign LINK.reg_ack = s_q.ack;
  assign USB_EN_O = s_q.usb_en;
  assign DP_EN_O = s_q.dp_en;
  assign CUSTOM_EN_O = s_q.cus_en;
  assign FLIP_O = s_q.flip;
  assign SINK_SIDE_O = s_q.sink;
  assign CABLE_O = s_q.cable;
  assign DP_LANES_O = s_q.lanes;
  assign SBU_ROUTE_O = s_q.route;
  assign DOWN_RX_EQ_O = s_q.eq_out[0];
  assign DOWN_TX_EQ_O = s_q.eq_out[1];
  assign UP_RX_EQ_O = s_q.eq_out[2];
  assign UP_TX_EQ_O = s_q.eq_out[3];
endmodule // rmc_device

// [design/rmc_host.sv]
// Controller end: AXI4-Lite registers drive the link pins and register port
`timescale 1ns/100ps
module rmc_host
  import rmc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // AXI4-Lite slave
  input wire logic [3:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [3:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Link to the redriver
  rmc_link_if.host LINK
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_WAIT = 2'b10
  } rmc_host_e;

  typedef struct packed {
    logic [15:0] ctrl;
    rmc_host_e st;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    logic lwr;
    logic aw_have;
    logic [3:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata_ax;
    logic [1:0] rresp;
  } rmc_host_s;

  rmc_host_s s_q, s_d;
  logic [31:0] cmd;

  always_comb
  begin
    s_d = s_q;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    cmd = rmc_merge(32'h0000_0000, s_q.w_data, s_q.w_strb);
    // Device answer
    if (s_q.st == H_WAIT && LINK.reg_ack)
    begin
      s_d.rdata = LINK.reg_rdata;
      s_d.st = H_IDLE;
    end
    // Write channels, either order
    if (S_AXI_AWVALID_I && s_q.awready)
    begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && s_q.wready)
    begin
      s_d.w_have = 1'b1;
      s_d.w_data = S_AXI_WDATA_I;
      s_d.w_strb = S_AXI_WSTRB_I;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (s_q.aw_addr)
        A_CTRL: s_d.ctrl = 16'(rmc_merge({16'h0000, s_q.ctrl}, s_q.w_data, s_q.w_strb));
        A_CMD:
        begin
          if (s_q.st != H_IDLE)
          begin
            s_d.bresp = RESP_SLVERR;
          end
          else
          begin
            s_d.addr = cmd[7:0];
            s_d.wdata = cmd[15:8];
            s_d.wr = cmd[CMD_WR_BIT]; // R05 R07
            s_d.rd = !cmd[CMD_WR_BIT];
            s_d.lwr = cmd[CMD_WR_BIT];
            s_d.st = H_WAIT;
          end
        end
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && S_AXI_BREADY_I)
    begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;
    // Read channel
    if (S_AXI_ARVALID_I && s_q.arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      case (S_AXI_ARADDR_I)
        A_CTRL: s_d.rdata_ax = {16'h0000, s_q.ctrl};
        A_CMD: s_d.rdata_ax = {15'h0000, s_q.lwr, s_q.wdata, s_q.addr};
        A_STAT: s_d.rdata_ax = {16'h0000, s_q.rdata, 7'h00, s_q.st == H_WAIT};
        default:
        begin
          s_d.rdata_ax = 32'h0000_0000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_q.rvalid && S_AXI_RREADY_I)
    begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.st <= H_IDLE;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Pins held from the control register
  assign LINK.interface_select = s_q.ctrl[0];
  assign LINK.usb_function_pin = s_q.ctrl[1]; // R06
  assign LINK.dp_function_pin = s_q.ctrl[2];
  assign LINK.hot_plug_input = s_q.ctrl[3]; // R09
  assign LINK.orientation_select = s_q.ctrl[4];
  assign LINK.direction_select_hi = s_q.ctrl[5];
  assign LINK.down_eq_pin_hi = s_q.ctrl[9:8];
  assign LINK.down_eq_pin_lo = s_q.ctrl[11:10];
  assign LINK.up_eq_pin_hi = s_q.ctrl[13:12];
  assign LINK.up_eq_pin_lo = s_q.ctrl[15:14];
  assign LINK.reg_addr = s_q.addr;
  assign LINK.reg_wdata = s_q.wdata;
  assign LINK.reg_wr = s_q.wr;
  assign LINK.reg_rd = s_q.rd;
  assign S_AXI_AWREADY_O = s_q.awready;
  assign S_AXI_WREADY_O = s_q.wready;
  assign S_AXI_BVALID_O = s_q.bvalid;
  assign S_AXI_BRESP_O = s_q.bresp;
  assign S_AXI_ARREADY_O = s_q.arready;
  assign S_AXI_RVALID_O = s_q.rvalid;
  assign S_AXI_RDATA_O = s_q.rdata_ax;
  assign S_AXI_RRESP_O = s_q.rresp;
endmodule // rmc_host

// [bench/rmc_link_sva.sv]
// Checker for the link and the mode outputs of the redriver pair
`timescale 1ns/100ps
module rmc_link_sva (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Link signals
  input wire logic interface_select,
  input wire logic usb_function_pin,
  input wire logic dp_function_pin,
  input wire logic direction_select_hi,
  input wire logic [1:0] down_eq_pin_hi,
  input wire logic [1:0] down_eq_pin_lo,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_ack,
  // Device mode outputs
  input wire logic USB_EN_O,
  input wire logic DP_EN_O,
  input wire logic CUSTOM_EN_O,
  input wire logic CABLE_O,
  input wire logic SINK_SIDE_O,
  input wire logic [2:0] DP_LANES_O,
  input wire logic [1:0] SBU_ROUTE_O,
  input wire logic [7:0] DOWN_RX_EQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  property p_ack;
    (reg_wr || reg_rd) |=> reg_ack ##1 !reg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("link access not acknowledged once");
  property p_ack_cause;
    reg_ack |-> $past(reg_wr) || $past(reg_rd);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without access");
  property p_cable;
    CABLE_O |-> !CUSTOM_EN_O && (USB_EN_O || DP_EN_O);
  endproperty
  a_cable: assert property (p_cable) else $error("cable mode with bad function set");
  property p_lanes;
    !CABLE_O |-> DP_LANES_O == (!DP_EN_O ? 3'h0 : (USB_EN_O ? 3'h2 : 3'h4));
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane count does not match functions");
  property p_route;
    $past(ARST_N_I) |-> SBU_ROUTE_O != 2'h0;
  endproperty
  a_route: assert property (p_route) else $error("sideband route code unused value");
  property p_sink;
    (!interface_select) [*8] |-> !SINK_SIDE_O;
  endproperty
  a_sink: assert property (p_sink) else $error("sink side set in pin mode");
  property p_gcable;
    (!interface_select && !usb_function_pin && !dp_function_pin) [*8] |-> CABLE_O;
  endproperty
  a_gcable: assert property (p_gcable) else $error("pins low but no cable mode");
  property p_gdp;
    (!interface_select && dp_function_pin && !direction_select_hi) [*8] |-> DP_EN_O;
  endproperty
  a_gdp: assert property (p_gdp) else $error("alt pin without display enable");
  property p_gcus;
    (!interface_select && dp_function_pin && direction_select_hi) [*8] |-> CUSTOM_EN_O && !DP_EN_O;
  endproperty
  a_gcus: assert property (p_gcus) else $error("alt pin without custom enable");
  property p_geq;
    (!interface_select && $stable(down_eq_pin_hi) && $stable(down_eq_pin_lo)) [*8]
      |-> DOWN_RX_EQ_O == {2{down_eq_pin_hi, down_eq_pin_lo}};
  endproperty
  a_geq: assert property (p_geq) else $error("pin equalization index wrong");
endmodule // rmc_link_sva

// [bench/tb_redriver_mode_control.sv]
// Testbench joining controller and redriver ends
`timescale 1ns/100ps
module tb_redriver_mode_control
  import rmc_pkg::*;
();
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic snoop_valid = 1'b0, usb_active = 1'b0;
  logic [2:0] snoop_lanes = 3'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic usb_en_o, dp_en_o, custom_en_o, flip_o, sink_side_o, cable_o;
  logic [2:0] dp_lanes_o;
  logic [1:0] sbu_route_o;
  logic [7:0] down_rx_eq_o, down_tx_eq_o, up_rx_eq_o, up_tx_eq_o;
  logic [9:0] mode;
  logic [31:0] eq;
  assign mode = {usb_en_o, dp_en_o, custom_en_o, flip_o, cable_o, dp_lanes_o, sbu_route_o};
  assign eq = {down_rx_eq_o, down_tx_eq_o, up_rx_eq_o, up_tx_eq_o};
  always #5 clk = ~clk;
  rmc_link_if lnk ();
  rmc_host i_rmc_host (.CLK_I(clk), .ARST_N_I(arst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .LINK(lnk.host));
  rmc_device #(.USB_WAIT_CYC(8)) i_rmc_device (.CLK_I(clk), .ARST_N_I(arst_n), .LINK(lnk.dev),
    .SNOOP_VALID_I(snoop_valid), .SNOOP_LANES_I(snoop_lanes), .USB_ACTIVE_I(usb_active),
    .USB_EN_O(usb_en_o), .DP_EN_O(dp_en_o), .CUSTOM_EN_O(custom_en_o), .FLIP_O(flip_o),
    .SINK_SIDE_O(sink_side_o), .CABLE_O(cable_o), .DP_LANES_O(dp_lanes_o), .SBU_ROUTE_O(sbu_route_o),
    .DOWN_RX_EQ_O(down_rx_eq_o), .DOWN_TX_EQ_O(down_tx_eq_o), .UP_RX_EQ_O(up_rx_eq_o), .UP_TX_EQ_O(up_tx_eq_o));
  rmc_link_sva i_rmc_link_sva (.CLK_I(clk), .ARST_N_I(arst_n), .interface_select(lnk.interface_select),
    .usb_function_pin(lnk.usb_function_pin), .dp_function_pin(lnk.dp_function_pin),
    .direction_select_hi(lnk.direction_select_hi), .down_eq_pin_hi(lnk.down_eq_pin_hi),
    .down_eq_pin_lo(lnk.down_eq_pin_lo), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd), .reg_ack(lnk.reg_ack),
    .USB_EN_O(usb_en_o), .DP_EN_O(dp_en_o), .CUSTOM_EN_O(custom_en_o), .CABLE_O(cable_o),
    .SINK_SIDE_O(sink_side_o), .DP_LANES_O(dp_lanes_o), .SBU_ROUTE_O(sbu_route_o), .DOWN_RX_EQ_O(down_rx_eq_o));

  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  function automatic logic [9:0] mk(input logic u, d, c, f, cb, input logic [2:0] l, input logic [1:0] r);
    mk = {u, d, c, f, cb, l, r};
  endfunction

  task automatic cm(input logic [9:0] e);
    chk({22'h00_0000, mode}, {22'h00_0000, e});
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Pin word to the controller, then let the synchroniser settle
  task automatic ctl(input logic [15:0] v);
    logic [1:0] r;
    wr(A_CTRL, {16'h0000, v}, r);
    repeat (12) @(posedge clk);
  endtask

  // Device register access through the command word
  task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [1:0] r;
    logic [31:0] s;
    wr(A_CMD, {15'h0000, w, d, a}, r);
    do rd(A_STAT, s, r);
    while (s[0] !== 1'b0);
    q = s[15:8];
    repeat (4) @(posedge clk);
  endtask

  task automatic dw(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    dev(1'b1, a, d, q);
  endtask

  task automatic snp(input logic [2:0] l);
    @(posedge clk);
    snoop_valid <= 1'b1;
    snoop_lanes <= l;
    @(posedge clk);
    snoop_valid <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge clk);
    cm(mk(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 2'h3));
    rd(A_CTRL, d, r);
    chk(d, {16'h0000, CTRL_RST});
    rd(4'hC, d, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, RESP_SLVERR});
    wr(4'hC, 32'hFFFF_FFFF, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, RESP_SLVERR});
  endtask

  task automatic t_gpio();
    logic [1:0] f;
    logic k;
    logic u;
    logic a;
    for (int i = 1; i < 8; i++)
    begin
      f = i[1:0];
      k = i[2];
      u = f[0];
      a = f[1];
      if (f != 2'h0)
      begin
        ctl({10'h000, k, k, 1'b0, f, 1'b0});
        cm(mk(u, a & ~k, a & k, k, 1'b0, (a & ~k) ? (u ? 3'h2 : 3'h4) : 3'h0, a ? (k ? 2'h2 : 2'h1) : 2'h3));
      end
    end
  endtask

  task automatic t_eq_gpio();
    logic [15:0] v[3] = '{16'h8702, 16'hFF02, 16'h0002};
    logic [7:0] dn;
    logic [7:0] up;
    foreach (v[j])
    begin
      ctl(v[j]);
      dn = {2{v[j][9:8], v[j][11:10]}};
      up = {2{v[j][13:12], v[j][15:14]}};
      chk(eq, {dn, dn, up, up});
    end
  endtask

  task automatic t_reg();
    logic [7:0] q;
    logic [31:0] d;
    logic [1:0] r;
    ctl(16'hFF05);
    dw(REG_SNOOP, 8'h00);
    dw(REG_GEN, 8'h1F);
    cm(mk(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 2'h2));
    chk({31'h0000_0000, sink_side_o}, 32'h0000_0001);
    dev(1'b0, REG_STAT, 8'h00, q);
    chk({24'h00_0000, q & 8'h8F}, 32'h0000_008D);
    for (int k = 1; k < 4; k++)
    begin
      dw(REG_SBU, k[7:0]);
      chk({30'h0000_0000, sbu_route_o}, k[31:0]);
    end
    dw(REG_SBU, 8'h00);
    dw(REG_GEN, 8'h03);
    cm(mk(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h2, 2'h1));
    rd(A_CMD, d, r);
    chk(d, {15'h0000, 1'b1, 8'h03, REG_GEN});
    for (int j = 0; j < 4; j++)
      dw(REG_EQ_BASE + j[7:0], 8'h21 + 8'h22 * j[7:0]);
    chk(eq, 32'h2143_6587);
  endtask

  task automatic t_cable();
    ctl(16'h0001);
    dw(REG_SNOOP, 8'h80);
    dw(REG_GEN, 8'h40);
    cm(mk(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 2'h3));
    usb_active <= 1'b1;
    ctl(16'h0009);
    repeat (20) @(posedge clk);
    cm(mk(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h2, 2'h1));
    usb_active <= 1'b0;
    repeat (14) @(posedge clk);
    cm(mk(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 3'h4, 2'h1));
    ctl(16'h0001);
    cm(mk(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 2'h3));
    dw(REG_SNOOP, 8'h00);
    ctl(16'h0009);
    cm(mk(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h2, 2'h1));
    snp(3'h1);
    cm(mk(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h1, 2'h1));
    snp(3'h3);
    cm(mk(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 3'h1, 2'h1));
    snp(3'h4);
    cm(mk(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 3'h4, 2'h1));
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_gpio();
    t_eq_gpio();
    t_reg();
    t_cable();
    tally_and_finish();
  end

  initial
  begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
endmodule // tb_redriver_mode_control
